/* File: pmpc_mac_model.sv */
/* pmpc_mac_model: mac transmit side of rmii, 160 ns reference clock.
   assumes the bench calls send; the clock stands low between frames. */
`default_nettype none
module pmpc_mac_model (
   // rmii transmit towards the device
   output var logic       ref_clk_out,
   output var logic       en_out,
   output var logic [1:0] data_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle state before any frame
   initial begin
      ref_clk_out = 1'b0;
      en_out = 1'b0;
      data_out = 2'h0;
   end
   // four dibits, lsb first; gap drops enable for dibit 1, close adds an idle edge
   task automatic send(input logic [7:0] b, input bit gap, input bit close);
      for (int i = 0; i < 4 + close; i++) begin
         #40;
         en_out = (i < 4) && !(gap && i == 1);
         data_out = en_out ? b[2*i +: 2] : ~data_out;
         #40 ref_clk_out = 1'b1;
         #80 ref_clk_out = 1'b0;
      end
   endtask : send
endmodule : pmpc_mac_model
`default_nettype wire

/* File: pmpc_pkg.sv */
/*
 pmpc_pkg: constants, types and register map of the multifunction pin control block.
 Assumes a single 200 MHz system clock domain with a synchronous active-high reset.
*/
// Functional notes
// [RULE1] data valid only while transmit enable high
// [RULE2] enable and data captured on reference rising edge
// [RULE3] master mode drives 50 MHz clock out
// [RULE4] output clock follows line recovered clock
// [RULE5] slave mode pin shows second indicator
// [RULE6] register setting makes pin gpio, overriding
// [RULE7] after reset shared pin is power-down input
// [RULE8] low level on pin means power-down
// [RULE9] software writes registers to select interrupt role
// [RULE10] interrupt role pulls pin low on interrupt
// [RULE11] interrupt output open-drain, released pulled high
// [RULE12] reset held 1 us restores defaults, resamples straps
// [RULE13] interrupt role ignores pin as power-down
`default_nettype none
package pmpc_pkg;
   // register offsets (word index on the plain port)
   localparam logic [3:0]  PMPC_REG_CTRL   = 4'h0;
   localparam logic [3:0]  PMPC_REG_STATUS = 4'h1;
   localparam logic [3:0]  PMPC_REG_MASK   = 4'h2;
   localparam logic [3:0]  PMPC_REG_GPIO   = 4'h3;
   localparam logic [3:0]  PMPC_REG_TXDATA = 4'h4;
   // control field positions
   localparam int          PMPC_CTRL_IRQ_SEL  = 0;
   localparam int          PMPC_CTRL_GPIO_SEL = 1;
   localparam int          PMPC_CTRL_LED2     = 2;
   // status / mask bit positions
   localparam int          PMPC_EV_TX_START = 0;
   localparam int          PMPC_EV_TX_END   = 1;
   localparam int          PMPC_EV_SLEEP    = 2;
   localparam int          PMPC_EV_EXT      = 3;
   localparam int          PMPC_EV_W        = 4;
   // reset values
   localparam logic [31:0] PMPC_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PMPC_MASK_RST = 32'h0000_0000;
   // reset minimum hold time
   localparam int          PMPC_SYS_CLK_MHZ = 200;
   localparam int          PMPC_RST_MIN_NS  = 1000;
   localparam int          PMPC_RST_CYCLES  = (PMPC_RST_MIN_NS * PMPC_SYS_CLK_MHZ + 999) / 1000;

   // shared clock/indicator pin function
   typedef enum logic [1:0] {
      PMPC_CLK_OUT  = 2'b00,
      PMPC_LED2_OUT = 2'b01,
      PMPC_GPIO     = 2'b10
   } pmpc_pin_fn_e;

   // one captured transmit symbol
   typedef struct packed {
      logic       valid;
      logic [1:0] data;
   } pmpc_tx_sym_s;

   // register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pmpc_reg_req_s;
endpackage : pmpc_pkg
`default_nettype wire

/* File: pmpc_props.sv */
/* pmpc_props: pin and transmit checks for pmpc_top, bound at its ports.
   assumes one clock domain and the register map of pmpc_pkg. */
`default_nettype none
module pmpc_props
   import pmpc_pkg::*;
(
   // clock, reset, strap and line clock
   input wire logic        sys_clk_in, reset_in, master_strap_in, recovered_clk_in,
   // transmit side
   input wire logic        tx_ref_clk_in, tx_en_in, tx_valid_out,
   input wire logic [1:0]  tx_data_in, tx_data_out,
   // shared pins and interrupt
   input wire logic        clock_or_indicator_pin_out, clock_or_indicator_pin_oe_n_out,
   input wire logic        second_indicator_in, irq_or_sleep_pin_in, irq_or_sleep_pin_out,
   input wire logic        irq_or_sleep_pin_oe_n_out, power_down_out, irq_out, reg_wr_in,
   // register writes
   input wire logic [3:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in
);
   logic [4:0] cfg_q, cfg_d;  // gpio drive, gpio value, control bits
   // mirror of control and gpio registers taken from the write strobes
   always_comb begin
      cfg_d = cfg_q;
      if (reg_wr_in && reg_addr_in == PMPC_REG_CTRL) cfg_d[2:0] = reg_wdata_in[2:0];
      if (reg_wr_in && reg_addr_in == PMPC_REG_GPIO) cfg_d[4:3] = reg_wdata_in[1:0];
   end
   always_ff @(posedge sys_clk_in) cfg_q <= reset_in ? 5'h00 : cfg_d;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   // enable and data taken at a reference rise, data zero while enable low
   property tx_cap_p;
      logic [2:0] s;
      ($rose(tx_ref_clk_in), s = {tx_en_in, tx_data_in})
         |-> ##5 {tx_valid_out, tx_data_out} == (s[2] ? s : 3'h0);
   endproperty
   tx_capture_a: assert property (tx_cap_p)
      else $error("tx capture wrong");
   pin_driven_a: assert property (
      !cfg_q[1] |-> !clock_or_indicator_pin_oe_n_out) else $error("clock pin not driven");
   indicator_a: assert property (
      !master_strap_in && cfg_q[2:1] == 2'h0 |-> clock_or_indicator_pin_out == second_indicator_in)
      else $error("indicator not shown");
   clk_follow_a: assert property (
      master_strap_in && !cfg_q[1] && $rose(recovered_clk_in)
         |-> ##[1:3] clock_or_indicator_pin_out ##2 !clock_or_indicator_pin_out)
      else $error("clock not followed");
   gpio_a: assert property (
      cfg_q[1] && $stable(cfg_q) |-> clock_or_indicator_pin_oe_n_out == !cfg_q[4]
         && (!cfg_q[4] || clock_or_indicator_pin_out == cfg_q[3]))
      else $error("gpio setting not applied");
   sleep_a: assert property (
      (!cfg_q[0] && $stable(irq_or_sleep_pin_in)) [*5] |-> power_down_out == !irq_or_sleep_pin_in)
      else $error("power-down not following pin");
   irq_role_a: assert property (
      cfg_q[0] && $past(cfg_q[0]) |-> !power_down_out) else $error("power-down in irq role");
   irq_pin_a: assert property (
      !irq_or_sleep_pin_out && irq_or_sleep_pin_oe_n_out == !(cfg_q[0] && irq_out))
      else $error("interrupt pin drive wrong");
   reset_dflt_a: assert property (
      @(posedge sys_clk_in) disable iff (1'b0) reset_in |=> !tx_valid_out && !power_down_out
         && !irq_out && irq_or_sleep_pin_oe_n_out) else $error("reset state wrong");
   // main scenarios reached
   cover property (tx_valid_out);
   cover property (!irq_or_sleep_pin_oe_n_out);
   cover property ($rose(power_down_out));
endmodule : pmpc_props
bind pmpc_top pmpc_props u_props (.*);
`default_nettype wire

/* File: pmpc_sync.sv */
/*
 pmpc_sync: two flip-flop synchroniser for a vector of asynchronous inputs.
 Assumes the destination clock is the system clock.
*/
`default_nettype none
module pmpc_sync
   import pmpc_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         reset_in,
   // data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // first stage feeds only the second stage
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule : pmpc_sync
`default_nettype wire

/* File: pmpc_tb.sv */
/* testbench: self-checking bench for pmpc_top with a mac model on transmit.
   assumes the register map and bit positions of pmpc_pkg. */
`default_nettype none
module testbench
   import pmpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk_in, reset_in = 1'b1, master_strap_in = 1'b0, recovered_clk_in = 1'b0;
   logic        second_indicator_in = 1'b0, ext_irq_in = 1'b0, pin_drv_q = 1'b1;
   logic        sleep_low_q = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [3:0]  reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out;
   logic [1:0]  tx_data_in, tx_data_out;
   logic        tx_ref_clk_in, tx_en_in, tx_valid_out, power_down_out, irq_out;
   logic        clock_or_indicator_pin_in, clock_or_indicator_pin_out;
   logic        clock_or_indicator_pin_oe_n_out, irq_or_sleep_pin_in;
   logic        irq_or_sleep_pin_out, irq_or_sleep_pin_oe_n_out;
   int          errors = 0, n_compared = 0, cycles = 0;
   // pin levels: device drive wins, interrupt pin has a pull-up
   assign clock_or_indicator_pin_in = clock_or_indicator_pin_oe_n_out ? pin_drv_q
                                      : clock_or_indicator_pin_out;
   assign irq_or_sleep_pin_in = !(sleep_low_q || !(irq_or_sleep_pin_oe_n_out
                                  || irq_or_sleep_pin_out));
   pmpc_top DUT (.*);
   pmpc_mac_model mac (.ref_clk_out(tx_ref_clk_in), .en_out(tx_en_in), .data_out(tx_data_in));
   // 200 MHz system clock
   initial begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   // 50 MHz line clock and run ceiling
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles[0]) recovered_clk_in <= ~recovered_clk_in;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chkb
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, exp);
   endtask : rd
   task automatic do_reset(input logic strap, input int n);
      @(posedge sys_clk_in);
      reset_in <= 1'b1;
      master_strap_in <= strap;
      repeat (n) @(posedge sys_clk_in);
      reset_in <= 1'b0;
   endtask : do_reset
   task automatic t_tx();
      mac.send(8'h9c, 1'b0, 1'b0);
      cyc(1);
      chkb(tx_valid_out, 1'b1);
      chk({30'h0, tx_data_out}, 32'h0000_0002);
      rd(PMPC_REG_TXDATA, 32'h0000_0006);
      mac.send(8'h5a, 1'b1, 1'b1);
      cyc(1);
      chkb(tx_valid_out, 1'b0);
      rd(PMPC_REG_STATUS, 32'h0000_0003);
      rd(PMPC_REG_STATUS, 32'h0000_0000);
   endtask : t_tx
   task automatic t_pin();
      for (int v = 0; v < 2; v++) begin
         @(posedge sys_clk_in);
         second_indicator_in <= v[0];
         cyc(1);
         chkb(clock_or_indicator_pin_out, v[0]);
      end
      @(posedge sys_clk_in);
      second_indicator_in <= 1'b0;
      wr(PMPC_REG_CTRL, 32'h0000_0004);
      cyc(1);
      chkb(clock_or_indicator_pin_out, 1'b1);
      wr(PMPC_REG_CTRL, 32'h0000_0002);
      wr(PMPC_REG_GPIO, 32'h0000_0003);
      cyc(1);
      chkb(clock_or_indicator_pin_out, 1'b1);
      wr(PMPC_REG_GPIO, 32'h0000_0000);
      cyc(4);
      chkb(clock_or_indicator_pin_oe_n_out, 1'b1);
      rd(PMPC_REG_GPIO, 32'h0000_0004);
      wr(PMPC_REG_CTRL, 32'h0000_0000);
   endtask : t_pin
   task automatic t_sleep();
      rd(PMPC_REG_CTRL, PMPC_CTRL_RST);
      rd(4'hf, 32'h0000_0000);
      chkb(power_down_out, 1'b0);
      @(posedge sys_clk_in);
      sleep_low_q <= 1'b1;
      cyc(5);
      chkb(power_down_out, 1'b1);
      @(posedge sys_clk_in);
      sleep_low_q <= 1'b0;
      cyc(5);
      chkb(power_down_out, 1'b0);
      rd(PMPC_REG_STATUS, 32'h0000_0004);
   endtask : t_sleep
   task automatic t_irq(input logic [31:0] mask);
      wr(PMPC_REG_MASK, mask);
      wr(PMPC_REG_CTRL, 32'h0000_0001);
      @(posedge sys_clk_in);
      ext_irq_in <= 1'b1;
      @(posedge sys_clk_in);
      ext_irq_in <= 1'b0;
      cyc(6);
      chkb(irq_or_sleep_pin_in, !mask[PMPC_EV_EXT]);
      chkb(power_down_out, 1'b0);
      chkb(irq_out, mask[PMPC_EV_EXT]);
      rd(PMPC_REG_STATUS, 32'h0000_0008);
      cyc(1);
      chkb(irq_or_sleep_pin_in, 1'b1);
      wr(PMPC_REG_CTRL, 32'h0000_0000);
   endtask : t_irq
   task automatic t_master();
      int   n;
      logic last;
      do_reset(1'b1, PMPC_RST_CYCLES);
      cyc(4);
      n = 0;
      last = clock_or_indicator_pin_out;
      repeat (40) begin
         cyc(1);
         if (clock_or_indicator_pin_out && !last) n++;
         last = clock_or_indicator_pin_out;
      end
      chk(n, 32'h0000_000a);
      rd(PMPC_REG_TXDATA, 32'h0000_0008);
   endtask : t_master
   task automatic summarize();
      if (errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   // main sequence
   initial begin
      do_reset(1'b0, 5);
      t_sleep();
      t_tx();
      t_pin();
      t_irq(32'h0000_0008);
      t_irq(32'h0000_0000);
      t_master();
      summarize();
   end
endmodule : testbench
`default_nettype wire

/* File: pmpc_top.sv */
/*
 pmpc_top: multifunction pin control of a 10/100 PHY: transmit capture, shared
 clock/indicator pin selection and shared interrupt/sleep pin.
 Assumes the transmit reference clock, recovered clock and pins are asynchronous
 to sys_clk_in and far slower than it; reset_in is synchronous to sys_clk_in.
*/
`default_nettype none
module pmpc_top
   import pmpc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   // strap and line-side
   input  wire logic        master_strap_in,
   input  wire logic        recovered_clk_in,
   // rmii transmit from the mac
   input  wire logic        tx_ref_clk_in,
   input  wire logic        tx_en_in,
   input  wire logic [1:0]  tx_data_in,
   output logic             tx_valid_out,
   output logic [1:0]       tx_data_out,
   // shared clock/indicator pin
   input  wire logic        clock_or_indicator_pin_in,
   output logic             clock_or_indicator_pin_out,
   output logic             clock_or_indicator_pin_oe_n_out,
   // shared interrupt/sleep pin
   input  wire logic        irq_or_sleep_pin_in,
   output logic             irq_or_sleep_pin_out,
   output logic             irq_or_sleep_pin_oe_n_out,
   output logic             power_down_out,
   // indicator and interrupt sources
   input  wire logic        second_indicator_in,
   input  wire logic        ext_irq_in,
   // register port
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic [31:0]      reg_rdata_out,
   output logic             irq_out
);
   localparam int SW = 6;

   // synchronised external levels
   logic [SW-1:0] raw_w;
   logic [SW-1:0] syn_w;
   logic          txclk_s;
   logic          txen_s;
   logic [1:0]    txd_s;
   logic          recclk_s;
   logic          sleep_req_s;

   // sleep pin enters inverted: a synchroniser cleared by reset then reads as
   // no request, so the idle-high pin gives no false power-down after reset
   assign raw_w = {tx_ref_clk_in, tx_en_in, tx_data_in, recovered_clk_in,
                   ~irq_or_sleep_pin_in};

   pmpc_sync #(.W(SW)) u_sync (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .async_in   (raw_w),
      .sync_out   (syn_w)
   );

   assign {txclk_s, txen_s, txd_s, recclk_s, sleep_req_s} = syn_w;

   // state
   logic         txclk_prev_q, txclk_prev_d;
   pmpc_tx_sym_s tx_q, tx_d;
   logic         recclk_prev_q, recclk_prev_d;
   logic         ref_clk_q, ref_clk_d;
   logic         strap_q, strap_d;
   logic         strap_taken_q, strap_taken_d;
   logic [31:0]  ctrl_q, ctrl_d;
   logic [PMPC_EV_W-1:0] status_q, status_d;
   logic [PMPC_EV_W-1:0] mask_q, mask_d;
   logic         gpio_out_q, gpio_out_d;
   logic         gpio_oe_q, gpio_oe_d;
   logic         txen_prev_q, txen_prev_d;
   logic         sleep_q, sleep_d;
   logic         ext_prev_q, ext_prev_d;
   logic [31:0]  rdata_q, rdata_d;
   logic         gpio_in_s1_q, gpio_in_s2_q;
   pmpc_pin_fn_e pin_fn;
   logic         rise_tx;
   logic         irq_role;
   logic [PMPC_EV_W-1:0] ev;

   // transmit capture on synchronised reference rising edge
   always_comb begin
      rise_tx       = txclk_s & ~txclk_prev_q;          // [RULE2]
      txclk_prev_d  = txclk_s;
      tx_d          = tx_q;
      if (rise_tx) begin
         tx_d.valid = txen_s;                             // [RULE1]
         tx_d.data  = txen_s ? txd_s : 2'b00;             // [RULE1]
      end
   end

   // master clock out follows each recovered-clock edge
   always_comb begin
      recclk_prev_d = recclk_s;
      ref_clk_d     = ref_clk_q;
      if (recclk_s != recclk_prev_q) begin
         ref_clk_d = recclk_s;                            // [RULE4]
      end
   end

   // strap caught once after reset release
   always_comb begin
      strap_taken_d = 1'b1;
      strap_d       = strap_taken_q ? strap_q : master_strap_in; // [RULE12]
   end

   // pin function selection
   always_comb begin
      if (ctrl_q[PMPC_CTRL_GPIO_SEL]) begin
         pin_fn = PMPC_GPIO;                              // [RULE6]
      end else if (strap_q) begin
         pin_fn = PMPC_CLK_OUT;                           // [RULE3]
      end else begin
         pin_fn = PMPC_LED2_OUT;                          // [RULE5]
      end
   end

   // sleep and interrupt role of the shared pin
   always_comb begin
      irq_role    = ctrl_q[PMPC_CTRL_IRQ_SEL];            // [RULE7] [RULE9]
      sleep_d     = ~irq_role & sleep_req_s;              // [RULE8] [RULE13]
      txen_prev_d = txen_s;
      ext_prev_d  = ext_irq_in;
      ev                   = '0;
      ev[PMPC_EV_TX_START] = rise_tx & txen_s & ~tx_q.valid;
      ev[PMPC_EV_TX_END]   = rise_tx & ~txen_s & tx_q.valid;
      ev[PMPC_EV_SLEEP]    = sleep_d & ~sleep_q;
      ev[PMPC_EV_EXT]      = ext_irq_in & ~ext_prev_q;
   end

   // register file: writes, read-clear status, read data
   always_comb begin
      ctrl_d     = ctrl_q;
      mask_d     = mask_q;
      gpio_out_d = gpio_out_q;
      gpio_oe_d  = gpio_oe_q;
      status_d   = status_q;
      rdata_d    = 32'h0000_0000;
      if (reg_wr_in) begin
         case (reg_addr_in)
            PMPC_REG_CTRL: ctrl_d = reg_wdata_in & 32'h0000_0007;
            PMPC_REG_MASK: mask_d = reg_wdata_in[PMPC_EV_W-1:0];
            PMPC_REG_GPIO: begin
               gpio_out_d = reg_wdata_in[0];
               gpio_oe_d  = reg_wdata_in[1];
            end
            default: ;
         endcase
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            PMPC_REG_CTRL:   rdata_d = ctrl_q;
            PMPC_REG_STATUS: begin
               rdata_d  = {{(32-PMPC_EV_W){1'b0}}, status_q};
               status_d = '0;
            end
            PMPC_REG_MASK:   rdata_d = {{(32-PMPC_EV_W){1'b0}}, mask_q};
            PMPC_REG_GPIO:   rdata_d = {29'h0000_0000, gpio_in_s2_q, gpio_oe_q, gpio_out_q};
            PMPC_REG_TXDATA: rdata_d = {28'h0000_0000, strap_q, tx_q.valid, tx_q.data};
            default:         rdata_d = 32'h0000_0000;
         endcase
      end
      status_d = status_d | ev;                            // set wins over clear
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin                                  // [RULE12]
         txclk_prev_q  <= 1'b0;
         tx_q          <= '0;
         recclk_prev_q <= 1'b0;
         ref_clk_q     <= 1'b0;
         strap_q       <= 1'b0;
         strap_taken_q <= 1'b0;
         ctrl_q        <= PMPC_CTRL_RST;
         mask_q        <= PMPC_MASK_RST[PMPC_EV_W-1:0];
         status_q      <= '0;
         gpio_out_q    <= 1'b0;
         gpio_oe_q     <= 1'b0;
         txen_prev_q   <= 1'b0;
         sleep_q       <= 1'b0;
         ext_prev_q    <= 1'b0;
         rdata_q       <= 32'h0000_0000;
         gpio_in_s1_q  <= 1'b0;
         gpio_in_s2_q  <= 1'b0;
      end else begin
         txclk_prev_q  <= txclk_prev_d;
         tx_q          <= tx_d;
         recclk_prev_q <= recclk_prev_d;
         ref_clk_q     <= ref_clk_d;
         strap_q       <= strap_d;
         strap_taken_q <= strap_taken_d;
         ctrl_q        <= ctrl_d;
         mask_q        <= mask_d;
         status_q      <= status_d;
         gpio_out_q    <= gpio_out_d;
         gpio_oe_q     <= gpio_oe_d;
         txen_prev_q   <= txen_prev_d;
         sleep_q       <= sleep_d;
         ext_prev_q    <= ext_prev_d;
         rdata_q       <= rdata_d;
         gpio_in_s1_q  <= clock_or_indicator_pin_in;
         gpio_in_s2_q  <= gpio_in_s1_q;
      end
   end

   // shared clock/indicator pin drive
   always_comb begin
      case (pin_fn)
         PMPC_CLK_OUT: begin
            clock_or_indicator_pin_out      = ref_clk_q;   // [RULE3] [RULE4]
            clock_or_indicator_pin_oe_n_out = 1'b0;
         end
         PMPC_LED2_OUT: begin
            clock_or_indicator_pin_out      = second_indicator_in
                                              | ctrl_q[PMPC_CTRL_LED2]; // [RULE5]
            clock_or_indicator_pin_oe_n_out = 1'b0;
         end
         PMPC_GPIO: begin
            clock_or_indicator_pin_out      = gpio_out_q;  // [RULE6]
            clock_or_indicator_pin_oe_n_out = ~gpio_oe_q;
         end
         default: begin
            clock_or_indicator_pin_out      = 1'b0;
            clock_or_indicator_pin_oe_n_out = 1'b1;
         end
      endcase
   end

   // open-drain interrupt pin and outputs
   assign irq_out                   = |(status_q & mask_q);
   assign irq_or_sleep_pin_out      = 1'b0;                               // [RULE11]
   assign irq_or_sleep_pin_oe_n_out = ~(irq_role & irq_out);               // [RULE10] [RULE11]
   assign power_down_out            = sleep_q;                             // [RULE8]
   assign tx_valid_out              = tx_q.valid;
   assign tx_data_out               = tx_q.data;
   assign reg_rdata_out             = rdata_q;
endmodule : pmpc_top
`default_nettype wire
